// [logic/adc_ctrl_defines.svh]
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// Register byte offsets
`define OFS_CLOCK_DIVIDER   8'h00
`define OFS_CONTROL_ZERO    8'h04
`define OFS_CONTROL_ONE     8'h08
`define OFS_RESULT_LOW      8'h0C
`define OFS_RESULT_MIDDLE   8'h10
`define OFS_RESULT_HIGH     8'h14
`define OFS_SYSTEM_CONTROL  8'h18
`define OFS_CHANNEL_SELECT  8'h1C

// Reset values
`define RST_CLOCK_DIVIDER   5'h00
`define RST_CONTROL_ZERO    8'h20
`define RST_CONTROL_ONE     8'h00
`define RST_FILTER_RESET    1'b0
`define RST_SLEEP_SELECT    1'b0
`define RST_POWER_OFF       1'b1
`define RST_OSR             3'h0
`define RST_REF_SELECT      1'b0
`define RST_CHOP            3'h0
`define RST_RESULT_HOLD     1'b0

// Control zero fields
`define BIT_FILTER_RESET    7
`define BIT_SLEEP_SELECT    6
`define BIT_POWER_OFF       5
`define POS_OSR_HI          4
`define POS_OSR_LO          2
`define BIT_REF_SELECT      0

// Control one fields
`define POS_CHOP_HI         7
`define POS_CHOP_LO         5
`define BIT_RESULT_HOLD     2
`define BIT_DONE            1

// System control fields
`define BIT_REGULATOR_EN    0
`define BIT_GLOBAL_INT_EN   1
`define BIT_CONV_INT_EN     2
`define BIT_IRQ_FLAG        3

// Divider and oversampling counts
`define DIV_BYPASS_CODE     5'h1F
`define OSR_MAX_COUNT       17'h04000
`define ADCK_DIV_LONG       5'd30
`define ADCK_DIV_SHORT      5'd12

`endif

// [logic/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;

   typedef enum logic [1:0] {
      MODE_POWER_DOWN,
      MODE_SLEEP,
      MODE_NORMAL,
      MODE_RESET
   } adc_mode_t;

   typedef logic signed [23:0] result_t;

   // Returns {chop_is_one, divide_by_short}
   function automatic logic [1:0] decode_chop(input logic [2:0] sel);
      return {sel[2], sel[1]};
   endfunction

endpackage

// [logic/sigma_delta_adc_control.sv]
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module sigma_delta_adc_control
   import adc_ctrl_pkg::*;
#(
   parameter logic [3:0] TEMP_POS_CODE = 4'hE,
   parameter logic [3:0] TEMP_NEG_CODE = 4'hE
) (
   input  wire  logic        CLK_IN,
   input  wire  logic        RST_IN,
   input  wire  logic        PSEL_IN,
   input  wire  logic        PENABLE_IN,
   input  wire  logic        PWRITE_IN,
   input  wire  logic [7:0]  PADDR_IN,
   input  wire  logic [31:0] PWDATA_IN,
   input  wire  logic        MOD_BIT_IN,
   output logic        [31:0] PRDATA_OUT,
   output logic               PREADY_OUT,
   output logic               PSLVERR_OUT,
   output logic        [1:0]  MODE_OUT,
   output logic               BANDGAP_EN_OUT,
   output logic               REGULATOR_EN_OUT,
   output logic               COMMON_MODE_EN_OUT,
   output logic               PGA_EN_OUT,
   output logic               MODULATOR_EN_OUT,
   output logic               TEMP_SENSOR_EN_OUT,
   output logic               FILTER_EN_OUT,
   output logic               FILTER_RESET_OUT,
   output logic               REF_SELECT_OUT,
   output logic               MASTER_CLK_TICK_OUT,
   output logic               IRQ_OUT
);

   logic [4:0]  clock_divide_select_q;
   logic        filter_reset_control_q;
   logic        converter_sleep_select_q;
   logic        converter_power_off_q;
   logic [2:0]  oversample_rate_select_q;
   logic        reference_pair_select_q;
   logic [2:0]  clock_chop_select_q;
   logic        result_hold_enable_q;
   logic        done_q;
   logic        regulator_enable_q;
   logic        global_interrupt_enable_q;
   logic        converter_interrupt_enable_q;
   logic        irq_flag_q;
   logic [3:0]  positive_channel_select_q;
   logic [3:0]  negative_channel_select_q;
   result_t     result_q;
   logic [1:0]  mod_sync_q;
   logic        filter_reset_prev_q;
   logic        started_q;
   logic [5:0]  mclk_cnt_q;
   logic        mclk_tick;
   logic [4:0]  adck_cnt_q;
   logic        adck_tick;
   logic [16:0] sample_cnt_q;
   logic [16:0] sample_target;
   result_t     acc_q;
   result_t     acc_next;
   logic        conv_end_q;
   result_t     conv_value_q;
   logic        running;
   adc_mode_t   mode_d;
   adc_mode_t   mode_q;
   logic        setup;
   logic        wr_en;
   logic        addr_ok;
   logic [31:0] rd_d;
   logic        temp_sel;
   logic [1:0]  chop_dec;

   assign setup = PSEL_IN && !PENABLE_IN;
   assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;

   always_comb begin
      addr_ok = 1'b1;
      rd_d    = 32'h0000_0000;
      unique case (PADDR_IN)
         `OFS_CLOCK_DIVIDER: rd_d = {27'h0, clock_divide_select_q};
         `OFS_CONTROL_ZERO: rd_d = {24'h0, filter_reset_control_q, converter_sleep_select_q,
                                    converter_power_off_q, oversample_rate_select_q, 1'b0,
                                    reference_pair_select_q};
         `OFS_CONTROL_ONE: rd_d = {24'h0, clock_chop_select_q, 2'b00, result_hold_enable_q,
                                   done_q, 1'b0};
         `OFS_RESULT_LOW: rd_d = {24'h0, result_q[7:0]};
         `OFS_RESULT_MIDDLE: rd_d = {24'h0, result_q[15:8]};
         `OFS_RESULT_HIGH: rd_d = {24'h0, result_q[23:16]};
         `OFS_SYSTEM_CONTROL: rd_d = {28'h0, irq_flag_q, converter_interrupt_enable_q,
                                      global_interrupt_enable_q, regulator_enable_q};
         `OFS_CHANNEL_SELECT: rd_d = {24'h0, negative_channel_select_q,
                                      positive_channel_select_q};
         default: addr_ok = 1'b0;
      endcase
   end

   // Bus answer: one access cycle, no wait states
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT  <= 32'h0000_0000;
      end else begin
         PREADY_OUT  <= setup;
         PSLVERR_OUT <= setup && !addr_ok;
         PRDATA_OUT  <= (setup && !PWRITE_IN) ? rd_d : 32'h0000_0000;
      end
   end

   // Software-written control registers
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         clock_divide_select_q        <= `RST_CLOCK_DIVIDER;
         filter_reset_control_q       <= `RST_FILTER_RESET;
         converter_sleep_select_q     <= `RST_SLEEP_SELECT;
         converter_power_off_q        <= `RST_POWER_OFF;
         oversample_rate_select_q     <= `RST_OSR;
         reference_pair_select_q      <= `RST_REF_SELECT;
         clock_chop_select_q          <= `RST_CHOP;
         result_hold_enable_q         <= `RST_RESULT_HOLD;
         regulator_enable_q           <= 1'b0;
         global_interrupt_enable_q    <= 1'b0;
         converter_interrupt_enable_q <= 1'b0;
         positive_channel_select_q    <= 4'h0;
         negative_channel_select_q    <= 4'h0;
      end else if (wr_en) begin
         if (PADDR_IN == `OFS_CLOCK_DIVIDER)
            clock_divide_select_q <= PWDATA_IN[4:0];
         if (PADDR_IN == `OFS_CONTROL_ZERO) begin
            filter_reset_control_q   <= PWDATA_IN[`BIT_FILTER_RESET];
            converter_sleep_select_q <= PWDATA_IN[`BIT_SLEEP_SELECT];
            converter_power_off_q    <= PWDATA_IN[`BIT_POWER_OFF];
            oversample_rate_select_q <= PWDATA_IN[`POS_OSR_HI:`POS_OSR_LO];
            reference_pair_select_q  <= PWDATA_IN[`BIT_REF_SELECT];
         end
         if (PADDR_IN == `OFS_CONTROL_ONE) begin
            clock_chop_select_q  <= PWDATA_IN[`POS_CHOP_HI:`POS_CHOP_LO];
            result_hold_enable_q <= PWDATA_IN[`BIT_RESULT_HOLD];
         end
         if (PADDR_IN == `OFS_SYSTEM_CONTROL) begin
            regulator_enable_q           <= PWDATA_IN[`BIT_REGULATOR_EN];
            global_interrupt_enable_q    <= PWDATA_IN[`BIT_GLOBAL_INT_EN];
            converter_interrupt_enable_q <= PWDATA_IN[`BIT_CONV_INT_EN];
         end
         if (PADDR_IN == `OFS_CHANNEL_SELECT) begin
            positive_channel_select_q <= PWDATA_IN[3:0];
            negative_channel_select_q <= PWDATA_IN[7:4];
         end
      end
   end

   // Done and request flags: a conversion end wins over a software write
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         done_q     <= 1'b0;
         irq_flag_q <= 1'b0;
      end else begin
         if (conv_end_q && !result_hold_enable_q)
            done_q <= 1'b1;
         else if (wr_en && PADDR_IN == `OFS_CONTROL_ONE)
            done_q <= PWDATA_IN[`BIT_DONE];
         if (conv_end_q && !result_hold_enable_q)
            irq_flag_q <= 1'b1;
         else if (wr_en && PADDR_IN == `OFS_SYSTEM_CONTROL)
            irq_flag_q <= PWDATA_IN[`BIT_IRQ_FLAG];
      end
   end

   // Operating mode decode
   always_comb begin
      if (converter_power_off_q)
         mode_d = MODE_POWER_DOWN;
      else if (converter_sleep_select_q)
         mode_d = MODE_SLEEP;
      else if (filter_reset_control_q)
         mode_d = MODE_RESET;
      else
         mode_d = MODE_NORMAL;
   end

   assign temp_sel = (positive_channel_select_q == TEMP_POS_CODE) ||
                     (negative_channel_select_q == TEMP_NEG_CODE);

   // Analog enables, registered one cycle after the control registers
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         mode_q             <= MODE_POWER_DOWN;
         BANDGAP_EN_OUT     <= 1'b0;
         REGULATOR_EN_OUT   <= 1'b0;
         COMMON_MODE_EN_OUT <= 1'b0;
         PGA_EN_OUT         <= 1'b0;
         MODULATOR_EN_OUT   <= 1'b0;
         TEMP_SENSOR_EN_OUT <= 1'b0;
         FILTER_EN_OUT      <= 1'b0;
         FILTER_RESET_OUT   <= 1'b0;
         REF_SELECT_OUT     <= 1'b0;
      end else begin
         mode_q             <= mode_d;
         BANDGAP_EN_OUT     <= (mode_d != MODE_POWER_DOWN) || regulator_enable_q;
         REGULATOR_EN_OUT   <= regulator_enable_q;
         COMMON_MODE_EN_OUT <= (mode_d != MODE_POWER_DOWN) || regulator_enable_q;
         PGA_EN_OUT         <= (mode_d != MODE_POWER_DOWN);
         MODULATOR_EN_OUT   <= (mode_d == MODE_NORMAL) || (mode_d == MODE_RESET);
         TEMP_SENSOR_EN_OUT <= ((mode_d == MODE_NORMAL) || (mode_d == MODE_RESET)) &&
                               temp_sel;
         FILTER_EN_OUT      <= (mode_d != MODE_POWER_DOWN);
         FILTER_RESET_OUT   <= (mode_d == MODE_RESET);
         REF_SELECT_OUT     <= reference_pair_select_q;
      end
   end

   assign MODE_OUT = mode_q;

   // Modulator bit stream synchroniser
   always_ff @(posedge CLK_IN) begin
      if (RST_IN)
         mod_sync_q <= 2'b00;
      else
         mod_sync_q <= {mod_sync_q[0], MOD_BIT_IN};
   end

   // Start on release of filter reset; power down disarms
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         filter_reset_prev_q <= 1'b0;
         started_q           <= 1'b0;
      end else begin
         filter_reset_prev_q <= filter_reset_control_q;
         if (converter_power_off_q)
            started_q <= 1'b0;
         else if (filter_reset_prev_q && !filter_reset_control_q)
            started_q <= 1'b1;
      end
   end

   assign running = started_q && (mode_q == MODE_NORMAL);

   // Master clock: system clock / 2 / (n + 1), or undivided
   assign mclk_tick = (clock_divide_select_q == `DIV_BYPASS_CODE) ||
                      (mclk_cnt_q == {clock_divide_select_q, 1'b1});

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         mclk_cnt_q          <= 6'h00;
         MASTER_CLK_TICK_OUT <= 1'b0;
      end else begin
         mclk_cnt_q          <= mclk_tick ? 6'h00 : mclk_cnt_q + 6'h01;
         MASTER_CLK_TICK_OUT <= mclk_tick;
      end
   end

   // Converter sample clock and chop decode
   assign chop_dec  = decode_chop(clock_chop_select_q);
   assign adck_tick = mclk_tick &&
                      (adck_cnt_q == (chop_dec[0] ? `ADCK_DIV_SHORT - 5'd1
                                                  : `ADCK_DIV_LONG - 5'd1));

   always_ff @(posedge CLK_IN) begin
      if (RST_IN || !running)
         adck_cnt_q <= 5'h00;
      else if (mclk_tick)
         adck_cnt_q <= adck_tick ? 5'h00 : adck_cnt_q + 5'h01;
   end

   // Samples per conversion: ratio times chop factor
   assign sample_target = (`OSR_MAX_COUNT >> oversample_rate_select_q) <<
                          (chop_dec[1] ? 1'b0 : 1'b1);
   assign acc_next = mod_sync_q[1] ? acc_q + 24'sh000001 : acc_q - 24'sh000001;

   // Decimation accumulator, cleared while not running
   always_ff @(posedge CLK_IN) begin
      if (RST_IN || !running) begin
         sample_cnt_q <= 17'h00000;
         acc_q        <= 24'sh000000;
         conv_end_q   <= 1'b0;
         conv_value_q <= 24'sh000000;
      end else begin
         conv_end_q <= 1'b0;
         if (adck_tick) begin
            if (sample_cnt_q == sample_target - 17'h00001) begin
               sample_cnt_q <= 17'h00000;
               acc_q        <= 24'sh000000;
               conv_end_q   <= 1'b1;
               conv_value_q <= acc_next;
            end else begin
               sample_cnt_q <= sample_cnt_q + 17'h00001;
               acc_q        <= acc_next;
            end
         end
      end
   end

   // Result bytes update unless held
   always_ff @(posedge CLK_IN) begin
      if (RST_IN)
         result_q <= 24'sh000000;
      else if (conv_end_q && !result_hold_enable_q)
         result_q <= conv_value_q;
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN)
         IRQ_OUT <= 1'b0;
      else
         IRQ_OUT <= irq_flag_q && global_interrupt_enable_q &&
                    converter_interrupt_enable_q;
   end

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   sequence reset_pulse_s;
      filter_reset_control_q ##1 !filter_reset_control_q;
   endsequence

   sequence new_result_s;
      conv_end_q && !result_hold_enable_q;
   endsequence

   div_bypass_a: assert property (clock_divide_select_q==`DIV_BYPASS_CODE |-> mclk_tick)
      else $error("bypass divider not ticking every cycle");
   div_period_a: assert property (
      mclk_tick && clock_divide_select_q == 5'h00 && $stable(clock_divide_select_q) && !PSEL_IN
      |=> !mclk_tick ##1 mclk_tick)
      else $error("divide by two period wrong");
   div_unused_a: assert property (setup && !PWRITE_IN && PADDR_IN == `OFS_CLOCK_DIVIDER
      |=> PRDATA_OUT[7:5] == 3'b000)
      else $error("divider upper bits not zero");
   power_down_a: assert property (converter_power_off_q
      |=> mode_q == MODE_POWER_DOWN && !PGA_EN_OUT && !MODULATOR_EN_OUT &&
          !TEMP_SENSOR_EN_OUT && !FILTER_EN_OUT)
      else $error("power down left blocks on");
   sleep_mode_a: assert property (!converter_power_off_q && converter_sleep_select_q
      |=> mode_q == MODE_SLEEP && !MODULATOR_EN_OUT && PGA_EN_OUT && FILTER_EN_OUT)
      else $error("sleep mode enables wrong");
   filter_hold_a: assert property (mode_d == MODE_RESET
      |=> FILTER_RESET_OUT && MODULATOR_EN_OUT ##1 !conv_end_q)
      else $error("filter not held in reset");
   cm_bandgap_a: assert property (COMMON_MODE_EN_OUT == BANDGAP_EN_OUT)
      else $error("common-mode source not with bandgap");
   start_arm_a: assert property (reset_pulse_s ##0 !converter_power_off_q |=> started_q)
      else $error("release did not start conversion");
   done_set_a: assert property (new_result_s |=> done_q && irq_flag_q)
      else $error("done or request flag not set");
   hold_keep_a: assert property (result_hold_enable_q |=> $stable(result_q))
      else $error("held result changed");
   irq_gate_a: assert property (IRQ_OUT |-> $past(global_interrupt_enable_q) &&
      $past(converter_interrupt_enable_q) && $past(irq_flag_q))
      else $error("interrupt raised while disabled");

endmodule // sigma_delta_adc_control

// [verification/test_sigma_delta_adc_control.sv]
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module test_sigma_delta_adc_control
   import adc_ctrl_pkg::*;
;
   logic        clk, rst, psel, penable, pwrite, mod_bit;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready, pslverr, bg, regen, cm, pga, modu, temp, fen, frst, refsel, tick, irq;
   logic [1:0]  mode;
   logic [31:0] rd;
   logic        err;
   logic [4:0]  n;
   logic [9:0]  e, s;
   int          mismatches;
   int          n_tests;
   int          seed;
   int          g;

   sigma_delta_adc_control dut (
      .CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .MOD_BIT_IN(mod_bit),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .MODE_OUT(mode),
      .BANDGAP_EN_OUT(bg), .REGULATOR_EN_OUT(regen), .COMMON_MODE_EN_OUT(cm),
      .PGA_EN_OUT(pga), .MODULATOR_EN_OUT(modu), .TEMP_SENSOR_EN_OUT(temp),
      .FILTER_EN_OUT(fen), .FILTER_RESET_OUT(frst), .REF_SELECT_OUT(refsel),
      .MASTER_CLK_TICK_OUT(tick), .IRQ_OUT(irq));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd  = prdata;
      err = pslverr;
      check("pready", {31'b0, pready}, 32'h1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic wait_done();
      int k;
      k = 0;
      do begin
         apb(1'b0, `OFS_CONTROL_ONE, 32'h0);
         k++;
      end while (rd[`BIT_DONE] !== 1'b1 && k < 1500);
   endtask

   task automatic res_chk(input logic [23:0] r);
      apb(1'b0, `OFS_RESULT_LOW, 32'h0);
      check("result low", rd, {24'h0, r[7:0]});
      apb(1'b0, `OFS_RESULT_MIDDLE, 32'h0);
      check("result middle", rd, {24'h0, r[15:8]});
      apb(1'b0, `OFS_RESULT_HIGH, 32'h0);
      check("result high", rd, {24'h0, r[23:16]});
   endtask

   // Cycles between master clock ticks
   task automatic tick_gap(output int t);
      t = 0;
      while (tick !== 1'b1 && t < 200) begin
         @(posedge clk);
         t++;
      end
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (tick !== 1'b1 && t < 200);
   endtask

   // Expected {mode, enables} from {regulator, power off, sleep, filter reset}
   function automatic logic [9:0] exp_ctl(input logic [3:0] c, input logic ts);
      logic ldo, po, sl, fr;
      {ldo, po, sl, fr} = c;
      return {po ? 2'd0 : sl ? 2'd1 : fr ? 2'd3 : 2'd2, ldo | !po, ldo, ldo | !po, !po,
              !po & !sl, !po & !sl & ts, !po, !po & !sl & fr};
   endfunction

   initial begin
      seed = 32'hF0F87832;
      {rst, psel, penable, pwrite, mod_bit} = 5'b10001;
      paddr  = 8'h00;
      pwdata = 32'h0;
      mismatches = 0;
      n_tests = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("mode at reset", {30'b0, mode}, 32'h0);
      apb(1'b0, `OFS_CLOCK_DIVIDER, 32'h0);
      check("divider reset", rd, 32'h0);
      apb(1'b0, `OFS_CONTROL_ZERO, 32'h0);
      check("control zero reset", rd, 32'h20);
      for (int k = 0; k < 8; k++) begin
         n = (k == 1) ? 5'h01 : (k == 2) ? 5'h1E : (k == 3) ? 5'h1F : 5'($random(seed));
         if (k == 0) n = 5'h00;
         if (k == 4) n = 5'h18;
         wr(`OFS_CLOCK_DIVIDER, {24'h0, 3'($random(seed)), n});
         apb(1'b0, `OFS_CLOCK_DIVIDER, 32'h0);
         check("divider readback", rd, {27'h0, n});
         tick_gap(g);
         tick_gap(g);
         check("tick gap", g, (n == 5'h1F) ? 32'd1 : 32'(2 * (n + 1)));
      end
      for (int i = 0; i < 32; i++) begin
         wr(`OFS_CHANNEL_SELECT, i[4] ? 32'h0E : i[0] ? 32'hE0 : 32'h00);
         wr(`OFS_SYSTEM_CONTROL, {31'h0, i[3]});
         wr(`OFS_CONTROL_ZERO, {24'h0, i[0], i[1], i[2], 4'h0, i[4]});
         repeat (3) @(posedge clk);
         e = exp_ctl(i[3:0], i[4] | i[0]);
         s = {mode, bg, regen, cm, pga, modu, temp, fen, frst};
         check("mode", {30'h0, s[9:8]}, {30'h0, e[9:8]});
         check("enables", {24'h0, s[7:0]}, {24'h0, e[7:0]});
         check("reference select", {31'h0, refsel}, {31'h0, i[4]});
      end
      mod_bit <= 1'b1;
      wr(`OFS_CLOCK_DIVIDER, 32'h1F);
      wr(`OFS_SYSTEM_CONTROL, 32'h07);
      wr(`OFS_CONTROL_ONE, 32'hC0);
      wr(`OFS_CONTROL_ZERO, 32'h9D);
      wr(`OFS_CONTROL_ZERO, 32'h1D);
      wait_done();
      check("done set", {31'h0, rd[`BIT_DONE]}, 32'h1);
      apb(1'b0, `OFS_SYSTEM_CONTROL, 32'h0);
      check("request flag", {31'h0, rd[`BIT_IRQ_FLAG]}, 32'h1);
      check("irq enabled", {31'h0, irq}, 32'h1);
      res_chk(24'h000080);
      wr(`OFS_SYSTEM_CONTROL, 32'h0D);
      repeat (2) @(posedge clk);
      check("irq no global", {31'h0, irq}, 32'h0);
      wr(`OFS_SYSTEM_CONTROL, 32'h0B);
      repeat (2) @(posedge clk);
      check("irq no local", {31'h0, irq}, 32'h0);
      mod_bit <= 1'b0;
      wr(`OFS_CONTROL_ONE, 32'hC0);
      wait_done();
      wr(`OFS_CONTROL_ONE, 32'hC0);
      wait_done();
      res_chk(24'hFFFF80);
      wr(`OFS_CONTROL_ONE, 32'hC4);
      wr(`OFS_CONTROL_ONE, 32'hC4);
      wr(`OFS_SYSTEM_CONTROL, 32'h07);
      repeat (3200) begin
         @(posedge clk);
         mod_bit <= 1'($random(seed));
      end
      mod_bit <= 1'b1;
      repeat (3200) @(posedge clk);
      apb(1'b0, `OFS_CONTROL_ONE, 32'h0);
      check("done held", {31'h0, rd[`BIT_DONE]}, 32'h0);
      apb(1'b0, `OFS_SYSTEM_CONTROL, 32'h0);
      check("flag held", {31'h0, rd[`BIT_IRQ_FLAG]}, 32'h0);
      check("irq held", {31'h0, irq}, 32'h0);
      res_chk(24'hFFFF80);
      wr(`OFS_CONTROL_ONE, 32'hC0);
      wait_done();
      res_chk(24'h000080);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped read", {err, rd[30:0]}, 32'h80000000);
      apb(1'b1, 8'h24, 32'hFF);
      check("unmapped write", {31'h0, err}, 32'h1);
      close_out();
   end

   initial begin
      repeat (80000) @(posedge clk);
      mismatches++;
      close_out();
   end
endmodule // test_sigma_delta_adc_control
